// ---- fcc_pkg.sv ----
// Package of constants and types for the forms carriage control block
package fcc_pkg;

  // ----------------------------------------------------------------
  // Sizes and codes
  // ----------------------------------------------------------------
  localparam int unsigned LINE_COUNT      = 180;
  localparam int unsigned ADDR_W          = 8;
  localparam logic [3:0]  STOP_CODE_NONE  = 4'h0;
  localparam logic [3:0]  STOP_CODE_MAX   = 4'hc;
  localparam int unsigned SENSE_BYTES     = 6;
  localparam int unsigned POS_STANDARD    = 132;
  localparam int unsigned POS_EXTENDED    = 150;
  localparam int unsigned MAX_SPACE       = 3;

  // ----------------------------------------------------------------
  // Load byte field positions
  // ----------------------------------------------------------------
  localparam int unsigned LB_LAST_BIT     = 7;
  localparam int unsigned LB_DENS_BIT     = 6;
  localparam int unsigned LB_RSVD_HI      = 5;
  localparam int unsigned LB_RSVD_LO      = 4;
  localparam int unsigned LB_CODE_HI      = 3;

  // ----------------------------------------------------------------
  // Sense byte 0 bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SB_CMD_REJECT   = 0;
  localparam int unsigned SB_LOAD_CHECK   = 1;
  localparam int unsigned SB_PARITY_CHECK = 2;
  localparam int unsigned SB_CODE_MISSING = 3;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [7:0]        BYTE_RESET = 8'h00;

  // Host commands
  typedef enum logic [2:0] {
    FCC_OP_SPACE,
    FCC_OP_SKIP,
    FCC_OP_LOAD,
    FCC_OP_CLEAR_SENSE
  } fcc_op_type;

  // Command from the channel
  typedef struct packed {
    fcc_op_type op;
    logic [3:0] arg;   // Line count for space, stop code for skip
  } fcc_cmd_type;

  // One forms buffer entry
  typedef struct packed {
    logic       last_line;
    logic       dens_8lpi;
    logic [3:0] stop_code;
  } fcc_entry_type;

  // Six sense bytes, byte 0 first
  typedef logic [SENSE_BYTES-1:0][7:0] fcc_sense_type;

endpackage

// ---- fcc_carriage.sv ----
// Forms carriage control: forms buffer, line address, space and skip
//----------------------------------------------------------------------
// Contract
// - The forms buffer holds 180 entries, one per print line.
// - Each entry can hold a stop code from 1 to 12.
// - The line address steps once for every line the paper advances.
// - A skip keeps advancing until the current entry has the code.
// - A skip whose code is absent stops when line 1 is seen twice.
// - A last-line flag in an entry ends a form shorter than 180 lines.
// - A flag in the first entry picks six or eight lines per inch.
// - A load with no last-line flag or a bad code raises an error.
// - Six bytes of sense data report the faults.
// - A print buffer parity error is sensed and blocks new space and skip commands; a move already under way runs on.
// - The print line has 132 positions, or 150 as an option.
//----------------------------------------------------------------------
module fcc_carriage #(
  parameter bit EXTENDED_LINE = 1'b0
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset,
  // Command port from the channel
  input  wire logic                      cmd_valid,
  input  wire fcc_pkg::fcc_cmd_type      cmd,
  output logic                           cmd_ready,
  // Forms buffer load data
  input  wire logic                      load_valid,
  input  wire logic [7:0]                load_byte,
  input  wire logic                      load_end,
  // Print line buffer status
  input  wire logic                      print_parity_err,
  // Carriage mechanism
  output logic                           advance_req,
  input  wire logic                      advance_done,
  // Status
  output logic [fcc_pkg::ADDR_W-1:0]     line_addr,
  output logic                           dens_8lpi,
  output logic                           motion_inhibit,
  output logic [7:0]                     print_positions,
  output fcc_pkg::fcc_sense_type         sense
);
  import fcc_pkg::*;

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_LOAD, ST_MOVE, ST_WAIT} fcc_state_type;

  fcc_state_type         state;
  fcc_entry_type         forms_line_buffer [LINE_COUNT];
  logic [ADDR_W-1:0]     load_ptr;
  logic                  load_saw_last;
  logic                  load_bad;
  logic                  is_skip;
  logic [3:0]            want_code;
  logic [1:0]            lines_left;
  logic [1:0]            line1_seen;
  logic [2:0]            done_sync;
  logic                  done_level;
  logic                  done_pulse;
  logic [ADDR_W-1:0]     next_addr;
  logic                  cmd_reject;
  logic                  load_check;
  logic                  parity_check;
  logic                  code_missing;
  logic                  take_cmd;
  logic                  moving_cmd;

  // Load byte is invalid when reserved bits are set or code is above 12
  function automatic logic byte_bad(input logic [7:0] b);
    return (b[LB_RSVD_HI:LB_RSVD_LO] != 2'h0) ||
           (b[LB_CODE_HI:0] > STOP_CODE_MAX);
  endfunction

  // Entry at an address ends the form
  function automatic logic ends_form(input logic [ADDR_W-1:0] a);
    return forms_line_buffer[a].last_line ||
           (a == ADDR_W'(LINE_COUNT - 1));
  endfunction

  assign take_cmd   = cmd_valid && cmd_ready;
  assign moving_cmd = (cmd.op == FCC_OP_SPACE) || (cmd.op == FCC_OP_SKIP);

  //--------------------------------------------------------------------
  // Carriage done input synchroniser
  //--------------------------------------------------------------------
  // Three stages; the level changes once stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_sync  <= 3'h0;
      done_level <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      done_sync  <= {done_sync[1:0], advance_done};
      done_pulse <= 1'b0;
      if (done_sync[2] == done_sync[1]) begin
        done_level <= done_sync[1];
        done_pulse <= done_sync[1] && !done_level;
      end
    end
  end

  // Address after one line, wrapping at the end of the form
  always_comb begin
    next_addr = line_addr + ADDR_W'(1);
    if (ends_form(line_addr)) begin
      next_addr = ADDR_RESET;
    end
  end

  //--------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------
  // Accepts commands, drives one line at a time, stops skips
  always_ff @(posedge mclk) begin
    if (reset) begin
      state       <= ST_IDLE;
      cmd_ready   <= 1'b0;
      advance_req <= 1'b0;
      line_addr   <= ADDR_RESET;
      is_skip     <= 1'b0;
      want_code   <= STOP_CODE_NONE;
      lines_left  <= 2'h0;
      line1_seen  <= 2'h0;
    end else begin
      advance_req <= 1'b0;
      case (state)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (take_cmd) begin
            if (cmd.op == FCC_OP_LOAD) begin
              cmd_ready <= 1'b0;
              line_addr <= ADDR_RESET;
              state     <= ST_LOAD;
            end else if (moving_cmd && !motion_inhibit &&
                         !(cmd.op == FCC_OP_SKIP &&
                           (cmd.arg == STOP_CODE_NONE ||
                            cmd.arg > STOP_CODE_MAX)) &&
                         !(cmd.op == FCC_OP_SPACE &&
                           (cmd.arg == 4'h0 ||
                            cmd.arg > 4'(MAX_SPACE)))) begin
              cmd_ready   <= 1'b0;
              is_skip     <= (cmd.op == FCC_OP_SKIP);
              want_code   <= cmd.arg;
              lines_left  <= cmd.arg[1:0];
              line1_seen  <= 2'h0;
              state       <= ST_MOVE;
            end
          end
        end
        ST_LOAD: begin
          if (load_end) begin
            state <= ST_IDLE;
          end
        end
        ST_MOVE: begin
          advance_req <= 1'b1;
          state       <= ST_WAIT;
        end
        ST_WAIT: begin
          if (done_pulse) begin
            line_addr <= next_addr;
            if (is_skip) begin
              if (forms_line_buffer[next_addr].stop_code ==
                  want_code) begin
                state <= ST_IDLE;
              end else if (next_addr == ADDR_RESET &&
                           line1_seen == 2'h1) begin
                state <= ST_IDLE;
              end else begin
                if (next_addr == ADDR_RESET) begin
                  line1_seen <= line1_seen + 2'h1;
                end
                state <= ST_MOVE;
              end
            end else if (lines_left == 2'h1) begin
              state <= ST_IDLE;
            end else begin
              lines_left <= lines_left - 2'h1;
              state      <= ST_MOVE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Forms buffer load
  //--------------------------------------------------------------------
  // Bytes beyond the last entry are checked but not stored
  always_ff @(posedge mclk) begin
    if (reset) begin
      load_ptr      <= ADDR_RESET;
      load_saw_last <= 1'b0;
      load_bad      <= 1'b0;
      for (int i = 0; i < LINE_COUNT; i++) begin
        forms_line_buffer[i] <= '0;
      end
    end else if (state == ST_IDLE && take_cmd &&
                 cmd.op == FCC_OP_LOAD) begin
      load_ptr      <= ADDR_RESET;
      load_saw_last <= 1'b0;
      load_bad      <= 1'b0;
    end else if (state == ST_LOAD && load_valid) begin
      if (load_ptr < ADDR_W'(LINE_COUNT)) begin
        forms_line_buffer[load_ptr].last_line <=
          load_byte[LB_LAST_BIT];
        forms_line_buffer[load_ptr].dens_8lpi <=
          load_byte[LB_DENS_BIT];
        forms_line_buffer[load_ptr].stop_code <=
          load_byte[LB_CODE_HI:0];
        load_ptr <= load_ptr + ADDR_W'(1);
      end
      load_saw_last <= load_saw_last || load_byte[LB_LAST_BIT];
      load_bad      <= load_bad || byte_bad(load_byte);
    end
  end

  //--------------------------------------------------------------------
  // Fault flags; a new event wins over a clear in the same cycle
  //--------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_reject     <= 1'b0;
      load_check     <= 1'b0;
      parity_check   <= 1'b0;
      code_missing   <= 1'b0;
      motion_inhibit <= 1'b0;
    end else begin
      if (take_cmd && cmd.op == FCC_OP_CLEAR_SENSE) begin
        cmd_reject     <= 1'b0;
        load_check     <= 1'b0;
        parity_check   <= 1'b0;
        code_missing   <= 1'b0;
        motion_inhibit <= 1'b0;
      end
      if (take_cmd && moving_cmd && state == ST_IDLE &&
          (motion_inhibit || cmd.arg == 4'h0 ||
           (cmd.op == FCC_OP_SKIP && cmd.arg > STOP_CODE_MAX) ||
           (cmd.op == FCC_OP_SPACE && cmd.arg > 4'(MAX_SPACE)))) begin
        cmd_reject <= 1'b1;
      end
      if (state == ST_LOAD && load_end &&
          (!(load_saw_last || (load_valid && load_byte[LB_LAST_BIT])) ||
           load_bad || (load_valid && byte_bad(load_byte)))) begin
        load_check <= 1'b1;
      end
      if (print_parity_err) begin
        parity_check   <= 1'b1;
        motion_inhibit <= 1'b1;
      end
      if (state == ST_WAIT && done_pulse && is_skip &&
          next_addr == ADDR_RESET && line1_seen == 2'h1 &&
          forms_line_buffer[next_addr].stop_code != want_code) begin
        code_missing <= 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------
  // Status outputs
  //--------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      dens_8lpi       <= 1'b0;
      print_positions <= BYTE_RESET;
      sense           <= '0;
    end else begin
      dens_8lpi       <= forms_line_buffer[0].dens_8lpi;
      print_positions <= EXTENDED_LINE ? 8'(POS_EXTENDED)
                                       : 8'(POS_STANDARD);
      sense           <= '0;
      sense[0][SB_CMD_REJECT]   <= cmd_reject;
      sense[0][SB_LOAD_CHECK]   <= load_check;
      sense[0][SB_PARITY_CHECK] <= parity_check;
      sense[0][SB_CODE_MISSING] <= code_missing;
      sense[1] <= line_addr;
      sense[2] <= {4'h0, want_code};
      sense[3] <= {6'h00, motion_inhibit, state != ST_IDLE};
    end
  end

endmodule

// ---- fcc_carriage_model.sv ----
// Carriage mechanism model answering line advance pulses
module fcc_carriage_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Line advance handshake
  input  wire logic       advance_req,
  input  wire logic [3:0] delay,
  output logic            advance_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;

  // Count down after each request; pin high two cycles, low otherwise
  always_ff @(posedge mclk) begin
    if (reset)
      cnt <= 5'h00;
    else if (advance_req)
      cnt <= {1'b0, delay} + 5'h03;
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
  assign advance_done = (cnt == 5'h01) || (cnt == 5'h02);
endmodule

// ---- fcc_carriage_props.sv ----
// Assertion checker for the forms carriage control block
module fcc_carriage_props #(
  parameter bit EXTENDED_LINE = 1'b0
) (
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         reset,
  // Command port
  input wire logic                         cmd_valid,
  input wire fcc_pkg::fcc_cmd_type         cmd,
  input wire logic                         cmd_ready,
  // Status and carriage
  input wire logic                         print_parity_err,
  input wire logic                         advance_req,
  input wire logic [fcc_pkg::ADDR_W-1:0]   line_addr,
  input wire logic                         motion_inhibit,
  input wire logic [7:0]                   print_positions,
  input wire fcc_pkg::fcc_sense_type       sense
);
  timeunit 1ns;
  timeprecision 1ps;
  import fcc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // Outputs quiet right after reset, fixed width, one-line pulses
  a_reset_quiet: assert property (
    $fell(reset) |-> !cmd_ready && !advance_req)
    else $error("busy output after reset");
  a_line_width: assert property (
    !$past(reset) && !$past(reset, 2) |->
      print_positions == (EXTENDED_LINE ? 8'h96 : 8'h84))
    else $error("wrong print position count");
  a_adv_pulse: assert property (advance_req |=> !advance_req)
    else $error("advance pulse too long");
  a_addr_bound: assert property (line_addr < 8'hb4)
    else $error("line address beyond buffer");
  a_addr_step: assert property (
    $changed(line_addr) && !$past(reset) |->
      line_addr == $past(line_addr) + 8'h01 || line_addr == 8'h00)
    else $error("line address jumped");
  a_inhibit_hold: assert property (
    motion_inhibit && cmd_ready |=> !advance_req [*2])
    else $error("paper moved while inhibited");
  a_parity_flag: assert property (
    print_parity_err |->
      ##[1:3] (sense[0][SB_PARITY_CHECK] && motion_inhibit))
    else $error("parity error not sensed");
  a_sense_spare: assert property (
    sense[4] == 8'h00 && sense[5] == 8'h00)
    else $error("spare sense bytes not zero");
  a_load_busy: assert property (
    cmd_valid && cmd_ready && cmd.op == FCC_OP_LOAD |=> !cmd_ready)
    else $error("load not taken");
endmodule

bind fcc_carriage fcc_carriage_props #(.EXTENDED_LINE(EXTENDED_LINE)) u_props (
  .mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .print_parity_err(print_parity_err),
  .advance_req(advance_req), .line_addr(line_addr),
  .motion_inhibit(motion_inhibit), .print_positions(print_positions),
  .sense(sense));

// ---- test_fcc_carriage.sv ----
// Self-checking bench for the forms carriage control block
module test_fcc_carriage;
  timeunit 1ns;
  timeprecision 1ps;
  import fcc_pkg::*;
  logic          mclk = 1'b0;
  logic          reset = 1'b1;
  logic          cmd_valid = 1'b0;
  fcc_cmd_type   cmd = '0;
  logic          load_valid = 1'b0;
  logic [7:0]    load_byte = 8'h00;
  logic          load_end = 1'b0;
  logic          print_parity_err = 1'b0;
  logic [3:0]    delay = 4'h0;
  logic          cmd_ready, advance_req, advance_done, dens_8lpi, inh;
  logic [7:0]    line_addr, print_positions, wide_positions;
  fcc_sense_type sense;
  logic [7:0]    img [0:179];
  logic [3:0]    bad_arg [4] = '{4'h0, 4'h4, 4'h0, 4'hd};
  int            n_mismatch = 0;
  int            checks = 0;
  int            n_adv = 0;
  int            base;

  fcc_carriage u_fcc_carriage (.mclk(mclk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .load_valid(load_valid), .load_byte(load_byte), .load_end(load_end),
    .print_parity_err(print_parity_err), .advance_req(advance_req),
    .advance_done(advance_done), .line_addr(line_addr),
    .dens_8lpi(dens_8lpi), .motion_inhibit(inh),
    .print_positions(print_positions), .sense(sense));
  fcc_carriage_model u_fcc_carriage_model (.mclk(mclk), .reset(reset),
    .advance_req(advance_req), .delay(delay), .advance_done(advance_done));
  // Second block with the long print line option, idle otherwise
  if (1) begin : g_wide
    fcc_carriage #(.EXTENDED_LINE(1'b1)) u_fcc_carriage (.mclk(mclk),
      .reset(reset), .cmd_valid(1'b0), .cmd(cmd), .cmd_ready(),
      .load_valid(1'b0), .load_byte(8'h00), .load_end(1'b0),
      .print_parity_err(1'b0), .advance_req(), .advance_done(1'b0),
      .line_addr(), .dens_8lpi(), .motion_inhibit(),
      .print_positions(wide_positions), .sense());
  end

  // Clock and a count of line advances
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (advance_req === 1'b1) n_adv++;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for the command port to go idle
  task automatic wait_ready();
    for (int i = 0; i < 8000; i++) begin
      @(posedge mclk);
      if (cmd_ready === 1'b1) return;
    end
    n_mismatch++;
    close_out();
  endtask

  // Offer a command, hold it until taken, wait for completion
  task automatic send(fcc_op_type op, logic [3:0] arg);
    cmd <= '{op, arg};
    cmd_valid <= 1'b1;
    wait_ready();
    cmd_valid <= 1'b0;
    wait_ready();
    repeat (3) @(posedge mclk);
  endtask

  task automatic move(fcc_op_type op, logic [3:0] arg, logic [7:0] a,
                      int adv);
    base = n_adv;
    send(op, arg);
    check("line_addr", line_addr, a);
    check("advances", 8'(n_adv - base), 8'(adv));
  endtask

  // Load command followed by one byte per cycle, load_end on the last
  task automatic load(int n);
    cmd <= '{FCC_OP_LOAD, 4'h0};
    cmd_valid <= 1'b1;
    wait_ready();
    cmd_valid <= 1'b0;
    for (int i = 0; i < n; i++) begin
      load_valid <= 1'b1;
      load_byte <= img[i];
      load_end <= (i == n - 1);
      @(posedge mclk);
    end
    load_valid <= 1'b0;
    load_end <= 1'b0;
    wait_ready();
    repeat (3) @(posedge mclk);
  endtask

  task automatic clr_img();
    foreach (img[i]) img[i] = 8'h00;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    check("positions", print_positions, 8'h00);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    check("positions", print_positions, 8'h84);
    check("wide", wide_positions, 8'h96);
    clr_img();
    img[0] = 8'h40;
    img[3] = 8'h05;
    img[9] = 8'h80;
    load(10);
    check("sense0", sense[0], 8'h00);
    check("density", {7'h00, dens_8lpi}, 8'h01);
    move(FCC_OP_SPACE, 4'h2, 8'h02, 2);
    move(FCC_OP_SKIP, 4'h5, 8'h03, 1);
    move(FCC_OP_SKIP, 4'h5, 8'h03, 10);
    delay <= 4'hc;
    move(FCC_OP_SKIP, 4'h7, 8'h00, 17);
    check("sense0", sense[0], 8'h08);
    send(FCC_OP_CLEAR_SENSE, 4'h0);
    for (int k = 0; k < 4; k++) begin
      move(k < 2 ? FCC_OP_SPACE : FCC_OP_SKIP, bad_arg[k], 8'h00, 0);
      check("sense0", sense[0], 8'h01);
      send(FCC_OP_CLEAR_SENSE, 4'h0);
    end
    for (int k = 0; k < 2; k++) begin
      clr_img();
      img[0] = k ? 8'h0d : 8'h00;
      img[2] = k ? 8'h80 : 8'h00;
      load(3);
      check("sense0", sense[0], 8'h02);
      send(FCC_OP_CLEAR_SENSE, 4'h0);
    end
    clr_img();
    for (int k = 1; k < 13; k++) img[k] = 8'(k);
    img[179] = 8'h80;
    load(180);
    check("density", {7'h00, dens_8lpi}, 8'h00);
    for (int k = 1; k < 13; k++) move(FCC_OP_SKIP, 4'(k), 8'(k), 1);
    move(FCC_OP_SPACE, 4'h3, 8'h0f, 3);
    move(FCC_OP_SKIP, 4'h1, 8'h01, 166);
    check("sense1", sense[1], 8'h01);
    check("sense2", sense[2], 8'h01);
    print_parity_err <= 1'b1;
    @(posedge mclk);
    print_parity_err <= 1'b0;
    repeat (4) @(posedge mclk);
    check("inhibit", {7'h00, inh}, 8'h01);
    check("sense3", sense[3], 8'h02);
    move(FCC_OP_SPACE, 4'h1, 8'h01, 0);
    check("sense0", sense[0], 8'h05);
    send(FCC_OP_CLEAR_SENSE, 4'h0);
    check("inhibit", {7'h00, inh}, 8'h00);
    close_out();
  end
endmodule
